//--- bench/msi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Host motion controller: drives the step, direction, enable and select pins.
module msi_host_model (
  input  wire logic       aclk,
  output var  logic       step,
  output var  logic       direction,
  output var  logic       enable,
  output var  logic       indexer_clear_n,
  output var  logic [2:0] microstep_resolution_select,
  output var  logic [2:0] waveform_select_bits
);

  // Pins start with the bridges held off and the indexer cleared.
  initial begin
    step = 1'b0;
    direction = 1'b0;
    enable = 1'b0;
    indexer_clear_n = 1'b0;
    microstep_resolution_select = 3'h0;
    waveform_select_bits = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lets a number of rising clock edges pass.
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Settings change well clear of any step edge, so none is sampled half-updated.
  task automatic setup(input logic [2:0] res, input logic dir, input logic [2:0] waveform_select);
    @(posedge aclk);
    microstep_resolution_select <= res;
    direction <= dir;
    waveform_select_bits <= waveform_select;
    wait_cycles(4);
  endtask

  // Drives the enable and clear levels, then lets them settle.
  task automatic lines(input logic en, input logic clr_n);
    @(posedge aclk);
    enable <= en;
    indexer_clear_n <= clr_n;
    wait_cycles(4);
  endtask

  // Each level lasts at least four cycles, four times the one cycle the edge detector needs.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      step <= 1'b1;
      wait_cycles(4);
      step <= 1'b0;
      wait_cycles(4);
    end
  endtask

endmodule

`default_nettype wire

//--- bench/test_microstep_indexer.sv
`timescale 1ns/1ps
`default_nettype none

module test_microstep_indexer;
  import msi_pkg::*;

  typedef struct packed {
    logic [2:0] res;
    logic       dir;
    logic [2:0] waveform_select;
    logic [7:0] n;
  } msi_row_t;

  logic        aclk = 1'b0;
  logic        aresetn;
  logic        step, direction, enable, indexer_clear_n;
  logic [2:0]  res_sel, wfs_sel;
  logic        bridge_enable, low_power, phase_a, phase_b;
  logic [11:0] vref_a, vref_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] d;
  logic [1:0]  r;
  logic [9:0]  ptr, pb;
  int          mismatches = 0;
  int          comparisons = 0;

  // Every resolution and table appears once, in both directions, with wraps.
  msi_row_t rows [8] = '{'{3'h0, 1'b1, 3'h0, 8'h03}, '{3'h1, 1'b1, 3'h1, 8'h05},
                         '{3'h2, 1'b0, 3'h2, 8'h04}, '{3'h3, 1'b0, 3'h3, 8'h07},
                         '{3'h4, 1'b1, 3'h4, 8'h09}, '{3'h5, 1'b1, 3'h5, 8'h03},
                         '{3'h6, 1'b0, 3'h6, 8'h06}, '{3'h7, 1'b1, 3'h7, 8'h05}};

  // A 100 MHz clock.
  always #5 aclk = ~aclk;

  msi_host_model host (
    .aclk                        (aclk),
    .step                        (step),
    .direction                   (direction),
    .enable                      (enable),
    .indexer_clear_n             (indexer_clear_n),
    .microstep_resolution_select (res_sel),
    .waveform_select_bits        (wfs_sel)
  );

  msi_indexer #(.DAC_W(12)) dut (
    .aclk, .aresetn, .step, .direction, .enable, .indexer_clear_n,
    .microstep_resolution_select (res_sel),
    .waveform_select_bits        (wfs_sel),
    .bridge_enable, .low_power, .phase_a, .phase_b, .vref_a, .vref_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                        output logic [1:0] rsp);
    logic aw_left;
    logic w_left;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (aw_left && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
  endtask

  // Read: rready stays up until the data word is sampled.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
  endtask

  // Table entries equal their own address, so a reference word names its position.
  task automatic check_pos(input logic [2:0] waveform_select, input logic dir);
    pb = dir ? ptr - 10'h100 : ptr + 10'h100;
    host.wait_cycles(3);
    axi_rd(OFF_STATUS, d, r);
    check(32'(d[9:0]), 32'(ptr));
    check(32'(d[ST_DIR_BIT]), 32'(dir));
    check(32'(vref_a), {20'h0, waveform_select, ptr[8:0]});
    check(32'(vref_b), {20'h0, waveform_select, pb[8:0]});
    check(32'({phase_a, phase_b}), 32'({ptr[9], pb[9]}));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short; the whole run needs about 17000 cycles.
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence: reset, table load, row loop, then the awkward cases.
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFF_CTRL, d, r);
    check(d, CTRL_RESET);
    axi_rd(OFF_TBL_ADDR, d, r);
    check(d, 32'(TBL_ADDR_RESET));
    check(32'({bridge_enable, low_power}), 32'h1);
    axi_wr(OFF_TBL_ADDR, 32'h0, 4'hf, r);
    for (int i = 0; i < 4096; i++) axi_wr(OFF_TBL_DATA, 32'(i), 4'hf, r);
    host.lines(1'b1, 1'b1);
    check(32'({bridge_enable, low_power}), 32'h2);
    ptr = 10'h0;
    for (int i = 0; i < 8; i++) begin
      host.setup(rows[i].res, rows[i].dir, rows[i].waveform_select);
      host.pulse(int'(rows[i].n));
      ptr = ptr + 10'((32'h1 << rows[i].res) * rows[i].n);
      check_pos(rows[i].waveform_select, rows[i].dir);
    end
    // Enable low: bridges off, references zero, steps ignored.
    host.lines(1'b0, 1'b1);
    check(32'({bridge_enable, low_power}), 32'h1);
    check(32'(vref_a), 32'h0);
    host.pulse(2);
    host.lines(1'b1, 1'b1);
    check_pos(3'h7, 1'b1);
    // Both-edge mode: one full pulse counts twice.
    axi_wr(OFF_CTRL, 32'h1, 4'hf, r);
    host.setup(3'h2, 1'b0, 3'h5);
    host.pulse(1);
    ptr = ptr + 10'h8;
    check_pos(3'h5, 1'b0);
    axi_wr(OFF_CTRL, 32'h0, 4'hf, r);
    // Clear: pointer back to zero, bridges off, steps ignored until release.
    host.lines(1'b1, 1'b0);
    axi_rd(OFF_STATUS, d, r);
    check(32'(d[9:0]), 32'h0);
    check(32'({d[ST_CLEAR_BIT], bridge_enable}), 32'h2);
    host.pulse(1);
    host.lines(1'b1, 1'b1);
    check(32'(bridge_enable), 32'h1);
    host.setup(3'h0, 1'b1, 3'h3);
    host.pulse(1);
    ptr = 10'h1;
    check_pos(3'h3, 1'b1);
    // An unmapped address is refused on both paths.
    axi_wr(8'h10, 32'h1, 4'hf, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h10, d, r);
    check({d[29:0], r}, 32'(RESP_SLVERR));
    // Byte lanes: only strobed lanes land, and a half table entry is dropped.
    axi_wr(OFF_CTRL, 32'h0000_0101, 4'h2, r);
    axi_rd(OFF_CTRL, d, r);
    check(d, 32'h0000_0100);
    axi_wr(OFF_TBL_DATA, 32'h0000_0fff, 4'h1, r);
    axi_rd(OFF_TBL_ADDR, d, r);
    check(d, 32'(TBL_ADDR_RESET));
    tally_and_finish();
  end

endmodule

`default_nettype wire

//--- core/msi_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module msi_edge_detect #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_bits,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev;

  if (WIDTH < 1) begin : g_bad_width
    $error("msi_edge_detect: WIDTH must be at least 1.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample the pins, then keep the previous sample to see both edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= '0;
      prev  <= '0;
    end else begin
      level <= in_bits;
      prev  <= level;
    end
  end

  // Edges come from two registered samples, so they are clean one-cycle pulses.
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

`default_nettype wire

//--- core/msi_indexer.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module msi_indexer #(
  parameter int unsigned DAC_W = 12
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         step,
  input  wire logic                         direction,
  input  wire logic                         enable,
  input  wire logic                         indexer_clear_n,
  input  wire logic [msi_pkg::SEL_W-1:0]    microstep_resolution_select,
  input  wire logic [msi_pkg::SEL_W-1:0]    waveform_select_bits,
  output logic                              bridge_enable,
  output logic                              low_power,
  output logic                              phase_a,
  output logic                              phase_b,
  output logic      [DAC_W-1:0]             vref_a,
  output logic      [DAC_W-1:0]             vref_b,
  input  wire logic [msi_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic      [1:0]                   s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [msi_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic      [31:0]                  s_axi_rdata,
  output logic      [1:0]                   s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import msi_pkg::*;

  if (DAC_W < 1 || DAC_W > 16) begin : g_bad_dac
    $error("msi_indexer: DAC_W must lie between 1 and 16.");
  end

  localparam int unsigned IN_W = 4 + 2 * SEL_W;

  logic [IN_W-1:0]   pin_level;
  logic [IN_W-1:0]   pin_rise;
  logic [IN_W-1:0]   pin_fall;
  logic              dir_lvl;
  logic              en_lvl;
  logic              clr_lvl;
  logic [SEL_W-1:0]  usm_lvl;
  logic [SEL_W-1:0]  wfs_lvl;
  logic              step_event;
  logic              run;
  logic [PTR_W-1:0]  ptr;
  logic [PTR_W-1:0]  inc;
  logic [PTR_W-1:0]  next_ptr;
  logic [PTR_W-1:0]  pos_b;
  logic              pol_a_d;
  logic              pol_b_d;
  logic [MEM_AW-1:0] rd_addr_a;
  logic [MEM_AW-1:0] rd_addr_b;
  logic [DAC_W-1:0]  rd_data_a;
  logic [DAC_W-1:0]  rd_data_b;
  logic [31:0]       ctrl;
  logic [11:0]       tbl_addr;
  logic              tbl_we;
  logic [DAC_W-1:0]  tbl_wdata;
  logic [11:0]       tbl_waddr;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic [AXI_AW-1:0] wr_word;
  logic [AXI_AW-1:0] rd_word;
  logic [31:0]       status;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling. Every host input is watched on both edges through one
  // detector; only the step edges are used, all other bits at their sampled level.
  msi_edge_detect #(
    .WIDTH (IN_W)
  ) u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_bits ({waveform_select_bits, microstep_resolution_select,
               indexer_clear_n, enable, direction, step}),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  assign dir_lvl  = pin_level[1];  // High means clockwise.
  assign en_lvl   = pin_level[2];
  assign clr_lvl  = pin_level[3];
  assign usm_lvl  = pin_level[4 +: SEL_W];
  assign wfs_lvl  = pin_level[4 + SEL_W +: SEL_W];

  // Rising step edges always count; falling ones only in both-edge mode.
  assign step_event = pin_rise[0] | (ctrl[CTRL_BOTH_EDGE_BIT] & pin_fall[0]);

  // The indexer runs only while enabled and not held in clear.
  assign run = en_lvl & clr_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Step pointer. The low bits index the table, the top bit is the winding
  // polarity, so crossing the table end flips polarity as a full step would.
  assign inc      = PTR_W'(1) << usm_lvl;
  assign next_ptr = ptr + inc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= PTR_RESET;
    end else if (!clr_lvl) begin
      ptr <= PTR_RESET;
    end else if (step_event && en_lvl) begin
      ptr <= next_ptr;
    end
  end

  // Winding B sits a fixed quarter cycle away; the sign follows direction so
  // that A leads clockwise and lags counter-clockwise at any resolution.
  assign pos_b = dir_lvl ? (ptr - QUAD_OFF) : (ptr + QUAD_OFF);

  // Table select bits form the upper address.
  assign rd_addr_a = {wfs_lvl, ptr[IDX_W-1:0]};
  assign rd_addr_b = {wfs_lvl, pos_b[IDX_W-1:0]};

  msi_wave_mem #(
    .AW (MEM_AW),
    .DW (DAC_W)
  ) u_tables (
    .aclk      (aclk),
    .wr_en     (tbl_we),
    .wr_addr   (tbl_waddr),
    .wr_data   (tbl_wdata),
    .rd_addr_a (rd_addr_a),
    .rd_addr_b (rd_addr_b),
    .rd_data_a (rd_data_a),
    .rd_data_b (rd_data_b)
  );

  // Polarity travels beside the table read so both reach the outputs together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_a_d <= 1'b0;
      pol_b_d <= 1'b0;
    end else begin
      pol_a_d <= ptr[PTR_W-1];
      pol_b_d <= pos_b[PTR_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver outputs. References read zero while the bridges are off, so the
  // DACs draw no current in low power.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bridge_enable <= 1'b0;
      low_power     <= 1'b1;
      phase_a       <= 1'b0;
      phase_b       <= 1'b0;
      vref_a        <= '0;
      vref_b        <= '0;
    end else begin
      bridge_enable <= run;
      low_power     <= ~en_lvl;
      phase_a       <= pol_a_d;
      phase_b       <= pol_b_d;
      vref_a        <= run ? rd_data_a : '0;
      vref_b        <= run ? rd_data_b : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side. Address and data are taken independently; the
  // response is raised once both are held, and both readies reopen after it.
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_word = {aw_addr[AXI_AW-1:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_word == OFF_CTRL || wr_word == OFF_STATUS ||
                         wr_word == OFF_TBL_ADDR || wr_word == OFF_TBL_DATA)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register, written per byte lane.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_fire && wr_word == OFF_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) begin
          ctrl[8*i +: 8] <= w_data[8*i +: 8];
        end
      end
    end
  end

  // Table loader. A data write stores one entry and steps the address, so a
  // whole table loads as a burst of data writes after one address write.
  // A data write without both low lanes is ignored to avoid half entries.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_addr  <= TBL_ADDR_RESET;
      tbl_we    <= 1'b0;
      tbl_waddr <= TBL_ADDR_RESET;
      tbl_wdata <= '0;
    end else begin
      tbl_we <= 1'b0;
      if (wr_fire && wr_word == OFF_TBL_ADDR) begin
        if (w_strb[0]) begin
          tbl_addr[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          tbl_addr[11:8] <= w_data[11:8];
        end
      end else if (wr_fire && wr_word == OFF_TBL_DATA && w_strb[1:0] == 2'b11) begin
        tbl_we    <= 1'b1;
        tbl_waddr <= tbl_addr;
        tbl_wdata <= w_data[DAC_W-1:0];
        tbl_addr  <= tbl_addr + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side. One read at a time; data come one cycle after the
  // address is taken.
  assign rd_word = {s_axi_araddr[AXI_AW-1:2], 2'b00};

  always_comb begin
    status                = '0;
    status[PTR_W-1:0]     = ptr;
    status[ST_BRIDGE_BIT] = bridge_enable;
    status[ST_LOWPWR_BIT] = low_power;
    status[ST_DIR_BIT]    = dir_lvl;
    status[ST_CLEAR_BIT]  = ~clr_lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (rd_word)
        OFF_CTRL:     s_axi_rdata <= ctrl;
        OFF_STATUS:   s_axi_rdata <= status;
        OFF_TBL_ADDR: s_axi_rdata <= {20'h0_0000, tbl_addr};
        OFF_TBL_DATA: s_axi_rdata <= '0;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the indexer behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TABLE_SELECT: assert property (rd_addr_a[MEM_AW-1:IDX_W] == wfs_lvl &&
                                     rd_addr_b[MEM_AW-1:IDX_W] == wfs_lvl)
    else $error("Table select does not follow the waveform bits.");

  AST_STEP_ADVANCE: assert property (step_event && run |=>
                                     ptr == PTR_W'($past(ptr) + (PTR_W'(1) << $past(usm_lvl))))
    else $error("Pointer did not advance by the selected increment.");

  AST_RISE_ONLY: assert property (!ctrl[CTRL_BOTH_EDGE_BIT] && pin_fall[0] && clr_lvl
                                  |=> $stable(ptr))
    else $error("Falling step edge moved the pointer.");

  AST_IDLE_HOLD: assert property (!step_event && clr_lvl |=> $stable(ptr))
    else $error("Pointer moved without a step.");

  AST_INC_POWER: assert property (inc == (PTR_W'(1) << usm_lvl) && $onehot(inc))
    else $error("Increment is not the selected power of two.");

  AST_QUADRATURE: assert property (PTR_W'(dir_lvl ? ptr - pos_b : pos_b - ptr) == QUAD_OFF)
    else $error("Winding B is not a quarter cycle from winding A.");

  AST_CLEAR_ZERO: assert property (!clr_lvl |=> ptr == PTR_RESET && !bridge_enable)
    else $error("Clear did not zero the pointer and stop the bridges.");

  AST_CLEAR_RELEASE: assert property ($rose(clr_lvl) && en_lvl |-> ptr == PTR_RESET
                                      ##1 bridge_enable)
    else $error("Bridges did not restart from position zero after clear.");

  AST_ENABLE_LOW: assert property (!en_lvl |=> !bridge_enable && low_power && vref_a == '0)
    else $error("Disabled indexer still drives the bridges.");

  AST_REF_LOAD: assert property (run && $past(run) |=> vref_a == $past(rd_data_a) &&
                                 vref_b == $past(rd_data_b))
    else $error("References do not carry the table entries.");

  AST_POLARITY: assert property (##2 phase_a == $past(ptr[PTR_W-1], 2))
    else $error("Winding A polarity does not follow the pointer.");

  COV_STEP: cover property (step_event && run ##1 $changed(ptr));
  COV_BOTH_EDGE: cover property (ctrl[CTRL_BOTH_EDGE_BIT] && pin_fall[0] && run);
  COV_CLEAR: cover property ($fell(clr_lvl) ##[1:20] $rose(clr_lvl));
  COV_WRAP: cover property (run && step_event && ptr[PTR_W-1] != next_ptr[PTR_W-1]);

endmodule

`default_nettype wire

//--- core/msi_pkg.sv
package msi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Table geometry and pointer arithmetic.
  localparam int unsigned TBL_COUNT   = 8;    // Number of waveform tables.
  localparam int unsigned SEL_W       = 3;    // Waveform and resolution select widths.
  localparam int unsigned TBL_ENTRIES = 512;  // Entries in one table.
  localparam int unsigned IDX_W       = 9;    // Table index width.
  localparam int unsigned PTR_W       = 10;   // Index plus one polarity bit.
  localparam int unsigned MEM_AW      = 12;   // Table select plus index.
  localparam logic [9:0]  QUAD_OFF    = 10'h100;  // Quarter of the electrical cycle.
  localparam logic [9:0]  PTR_RESET   = 10'h000;  // Pointer value after clear.

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses of 32-bit words.
  localparam int unsigned AXI_AW       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_TBL_ADDR = 8'h08;
  localparam logic [7:0]  OFF_TBL_DATA = 8'h0c;

  // Field positions.
  localparam int unsigned CTRL_BOTH_EDGE_BIT = 0;
  localparam int unsigned ST_BRIDGE_BIT      = 16;
  localparam int unsigned ST_LOWPWR_BIT      = 17;
  localparam int unsigned ST_DIR_BIT         = 18;
  localparam int unsigned ST_CLEAR_BIT       = 19;

  // Reset values and bus answers.
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [11:0] TBL_ADDR_RESET = 12'h000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

//--- core/msi_wave_mem.sv
`timescale 1ns/1ps
`default_nettype none

module msi_wave_mem #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 12
) (
  input  wire logic          aclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr_a,
  input  wire logic [AW-1:0] rd_addr_b,
  output logic      [DW-1:0] rd_data_a,
  output logic      [DW-1:0] rd_data_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // One write port from software, two registered read ports for the windings.
  // Contents are not reset; software must load the tables before motion.
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end

endmodule

`default_nettype wire
